// >>> core/tpm_test_pin_mux.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module tpm_test_pin_mux
  import tpm_pkg::*;
(
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Write address channel.
  input logic [AXI_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input logic [AXI_DW-1:0] s_axi_wdata,
  input logic [AXI_SW-1:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // Read address channel.
  input logic [AXI_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Internal sources.
  input tpm_src_t src,
  // Serial read port state.
  input logic serial_read_active,
  input logic serial_read_data,
  // Shared pin.
  output tpm_pin_t lock_or_read_data_pin
);

  function automatic logic [AXI_DW-1:0] strb_merge(
    logic [AXI_DW-1:0] old_v,
    logic [AXI_DW-1:0] new_v,
    logic [AXI_SW-1:0] strb
  );
    logic [AXI_DW-1:0] v;
    v = old_v;
    for (int b = 0; b < AXI_SW; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return v;
  endfunction

  // Registers.
  logic [AXI_DW-1:0] ctrl_q;
  logic [AXI_DW-1:0] ctrl_d;
  logic [AXI_DW-1:0] sel_reg_q;
  logic [AXI_DW-1:0] sel_reg_d;

  // Write channel state.
  logic aw_hold_q;
  logic aw_hold_d;
  logic [AXI_AW-1:0] awaddr_q;
  logic w_hold_q;
  logic w_hold_d;
  logic [AXI_DW-1:0] wdata_q;
  logic [AXI_SW-1:0] wstrb_q;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // Read channel state.
  logic rvalid_q;
  logic rvalid_d;
  logic [AXI_DW-1:0] rdata_q;
  logic [AXI_DW-1:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  // Decode.
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [AXI_SW-1:0] wr_strb;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_hit;
  logic rd_ctrl;
  logic rd_sel;
  logic rd_stat;
  logic [AXI_DW-1:0] stat_word;
  logic [AXI_DW-1:0] rd_word;

  // Block signals.
  tpm_sel_t sel;
  logic general_purpose_output;
  tpm_pin_t pin;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order; the write happens once both are here.
  assign do_write = (aw_hold_q || aw_fire) && (w_hold_q || w_fire);
  assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;

  assign wr_ctrl = do_write && (wr_addr == CTRL_OFS);
  assign wr_sel = do_write && (wr_addr == SEL_OFS);
  assign wr_hit = (wr_addr == CTRL_OFS) || (wr_addr == SEL_OFS);

  assign ctrl_d = wr_ctrl ? (strb_merge(ctrl_q, wr_data, wr_strb) & CTRL_MASK) : ctrl_q;
  assign sel_reg_d = wr_sel ? (strb_merge(sel_reg_q, wr_data, wr_strb) & SEL_MASK) : sel_reg_q;

  assign aw_hold_d = do_write ? 1'b0 : (aw_fire ? 1'b1 : aw_hold_q);
  assign w_hold_d = do_write ? 1'b0 : (w_fire ? 1'b1 : w_hold_q);
  assign bvalid_d = do_write ? 1'b1 : (s_axi_bready ? 1'b0 : bvalid_q);
  assign bresp_d = do_write ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      sel_reg_q <= SEL_RST;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      ctrl_q <= ctrl_d;
      sel_reg_q <= sel_reg_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // Payload registers carry no control meaning, so they skip the reset.
  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      awaddr_q <= s_axi_awaddr;
    end
    if (w_fire) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read path.
  assign rd_ctrl = s_axi_araddr == CTRL_OFS;
  assign rd_sel = s_axi_araddr == SEL_OFS;
  assign rd_stat = s_axi_araddr == STAT_OFS;

  assign stat_word = (AXI_DW'(pin.level) << STAT_LEVEL_BIT)
    | (AXI_DW'(pin.oe) << STAT_OE_BIT)
    | (AXI_DW'(pin.high_side_en) << STAT_HS_BIT)
    | (AXI_DW'(serial_read_active) << STAT_RD_BIT)
    | (AXI_DW'(sel) << STAT_SEL_LSB);

  assign rd_word = rd_ctrl ? ctrl_q : (rd_sel ? sel_reg_q : (rd_stat ? stat_word : '0));
  assign rvalid_d = ar_fire ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_q);
  assign rdata_d = ar_fire ? rd_word : rdata_q;
  assign rresp_d = ar_fire ? ((rd_ctrl || rd_sel || rd_stat) ? RESP_OKAY : RESP_SLVERR) : rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Output selection and pin stage.
  assign sel = sel_reg_q[SEL_W-1:0];

  tpm_gpo_select u_select (
    .sel(sel),
    .test_level(ctrl_q[TEST_BIT]),
    .src(src),
    .general_purpose_output(general_purpose_output)
  );

  tpm_pin_stage u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .general_purpose_output(general_purpose_output),
    .serial_read_active(serial_read_active),
    .serial_read_data(serial_read_data),
    .disable_read_data_auto_switch(ctrl_q[AUTO_OFF_BIT]),
    .pin_driver_force_on(ctrl_q[FORCE_ON_BIT]),
    .high_side_off(ctrl_q[HS_OFF_BIT]),
    .pin(pin)
  );

  assign lock_or_read_data_pin = pin;

  // Checks.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ref_div_route: assert property (
    sel == SEL_REF_DIV |-> general_purpose_output == src.ref_div)
    else $error("reference divider not routed");

  a_osc_div_route: assert property (
    sel == SEL_OSC_DIV |-> general_purpose_output == src.osc_div)
    else $error("oscillator divider not routed");

  a_aux_dout_route: assert property (
    sel == SEL_AUX_DOUT && ctrl_q[AUTO_OFF_BIT] |=> pin.level == $past(src.aux_dout))
    else $error("auxiliary data not on pin");

  a_pd_up_route: assert property (
    sel == SEL_PD_UP |-> general_purpose_output == src.pd_up)
    else $error("detector up pulse not routed");

  a_stb_frac_route: assert property (
    sel == SEL_STB_FRAC |-> general_purpose_output == src.stb_frac)
    else $error("fraction strobe not routed");

  a_seed_route: assert property (
    sel == SEL_SEED |-> general_purpose_output == src.seed_load)
    else $error("seed strobe not routed");

  a_unused_low: assert property (
    sel >= SEL_UNUSED_LO && sel <= SEL_UNUSED_HI |-> !general_purpose_output)
    else $error("unused code drives a level");

  a_soft_rst_route: assert property (
    sel == SEL_SOFT_RST |-> general_purpose_output == src.soft_rst)
    else $error("soft reset not routed");

  a_test_level: assert property (
    sel == SEL_TEST |-> general_purpose_output == ctrl_q[TEST_BIT])
    else $error("test level not routed");

  a_auto_switch: assert property (
    !ctrl_q[AUTO_OFF_BIT] && serial_read_active |=> pin.level == $past(serial_read_data))
    else $error("read data not switched onto pin");

  a_driver_enable: assert property (
    ##1 pin.oe == ($past(ctrl_q[FORCE_ON_BIT]) || $past(serial_read_active)))
    else $error("pin driver enable wrong");

  a_high_side: assert property (
    ##1 pin.high_side_en == !$past(ctrl_q[HS_OFF_BIT]))
    else $error("high-side drive wrong");

  a_sel_by_write: assert property (
    $changed(sel) |-> $past(wr_sel) && $rose(s_axi_bvalid))
    else $error("select changed without a write");

  a_aux_clk_route: assert property (
    sel == SEL_AUX_CLK |-> general_purpose_output == src.aux_clk)
    else $error("auxiliary clock not routed");

  a_aux_en_route: assert property (
    sel == SEL_AUX_EN |-> general_purpose_output == src.aux_en)
    else $error("auxiliary enable not routed");

  a_pd_down_route: assert property (
    sel == SEL_PD_DOWN |-> general_purpose_output == src.pd_down)
    else $error("detector down pulse not routed");

  a_stb_int_route: assert property (
    sel == SEL_STB_INT |-> general_purpose_output == src.stb_int)
    else $error("integer strobe not routed");

  a_stb_aux_route: assert property (
    sel == SEL_STB_AUX |-> general_purpose_output == src.stb_aux)
    else $error("auxiliary strobe not routed");

  a_latch_route: assert property (
    sel == SEL_LATCH |-> general_purpose_output == src.latch_en)
    else $error("latch enable not routed");

  a_div_rst_route: assert property (
    sel == SEL_DIV_RST |-> general_purpose_output == src.div_sync_rst)
    else $error("divider reset not routed");

  a_buf_en_route: assert property (
    sel == SEL_BUF_EN |-> general_purpose_output == src.out_buf_en)
    else $error("buffer enable not routed");

  a_level_gpo: assert property (
    ctrl_q[AUTO_OFF_BIT] |=> pin.level == $past(general_purpose_output))
    else $error("pin level not the selected output");

  a_ctrl_mask: assert property (
    (ctrl_q & ~CTRL_MASK) == '0)
    else $error("control holds bits outside its fields");

  a_sel_mask: assert property (
    (sel_reg_q & ~SEL_MASK) == '0)
    else $error("select holds bits outside its field");

  a_write_okay: assert property (
    do_write && wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered okay");

  a_write_slverr: assert property (
    do_write && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  a_read_slverr: assert property (
    ar_fire && !(rd_ctrl || rd_sel || rd_stat) |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  a_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");

  a_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");

  c_sel_write: cover property (wr_sel ##1 s_axi_bvalid && s_axi_bready);
  c_stat_read: cover property (ar_fire && rd_stat ##1 s_axi_rvalid);
  c_read_switch: cover property (!ctrl_q[AUTO_OFF_BIT] && serial_read_active ##1 pin.oe);
  c_force_on: cover property (ctrl_q[FORCE_ON_BIT] && !serial_read_active ##1 pin.oe);
  c_unused_code: cover property (sel == SEL_UNUSED_LO ##1 !general_purpose_output);

endmodule

// >>> core/tpm_pkg.sv
// Operation
// - Codes 9/10 select reference/oscillator divider
// - Codes 13-15 select auxiliary clock/enable/data
// - Codes 16/17 select detector down/up pulse
// - Codes 20-22 select integer/fraction/auxiliary strobes
// - Codes 23-25 select latch, divider reset, seed
// - Codes 26-29 unused; 30 selects buffer enable
// - Code 31 selects internal soft reset
// - Bit 5 static test level, default 0
// - Bit 6 forces output data, no auto-switch
// - Bit 7 keeps driver on, else reads only
// - Bit 8 set disables high-side drive
package tpm_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;

  // Register byte offsets.
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] SEL_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] STAT_OFS = 8'h08;

  // Control register fields and reset value.
  localparam int TEST_BIT = 5;
  localparam int AUTO_OFF_BIT = 6;
  localparam int FORCE_ON_BIT = 7;
  localparam int HS_OFF_BIT = 8;
  localparam logic [AXI_DW-1:0] CTRL_MASK = 32'h0000_01E0;
  localparam logic [AXI_DW-1:0] CTRL_RST = 32'h0000_0000;

  // Select register.
  localparam int SEL_W = 5;
  localparam logic [AXI_DW-1:0] SEL_MASK = 32'h0000_001F;
  localparam logic [AXI_DW-1:0] SEL_RST = 32'h0000_0000;

  // Status register fields.
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_OE_BIT = 1;
  localparam int STAT_HS_BIT = 2;
  localparam int STAT_RD_BIT = 3;
  localparam int STAT_SEL_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [SEL_W-1:0] tpm_sel_t;

  // Select codes.
  localparam tpm_sel_t SEL_TEST = 5'h01;
  localparam tpm_sel_t SEL_REF_DIV = 5'h09;
  localparam tpm_sel_t SEL_OSC_DIV = 5'h0A;
  localparam tpm_sel_t SEL_AUX_CLK = 5'h0D;
  localparam tpm_sel_t SEL_AUX_EN = 5'h0E;
  localparam tpm_sel_t SEL_AUX_DOUT = 5'h0F;
  localparam tpm_sel_t SEL_PD_DOWN = 5'h10;
  localparam tpm_sel_t SEL_PD_UP = 5'h11;
  localparam tpm_sel_t SEL_STB_INT = 5'h14;
  localparam tpm_sel_t SEL_STB_FRAC = 5'h15;
  localparam tpm_sel_t SEL_STB_AUX = 5'h16;
  localparam tpm_sel_t SEL_LATCH = 5'h17;
  localparam tpm_sel_t SEL_DIV_RST = 5'h18;
  localparam tpm_sel_t SEL_SEED = 5'h19;
  localparam tpm_sel_t SEL_UNUSED_LO = 5'h1A;
  localparam tpm_sel_t SEL_UNUSED_HI = 5'h1D;
  localparam tpm_sel_t SEL_BUF_EN = 5'h1E;
  localparam tpm_sel_t SEL_SOFT_RST = 5'h1F;

  typedef struct packed {
    logic ref_div;
    logic osc_div;
    logic aux_clk;
    logic aux_en;
    logic aux_dout;
    logic pd_down;
    logic pd_up;
    logic stb_int;
    logic stb_frac;
    logic stb_aux;
    logic latch_en;
    logic div_sync_rst;
    logic seed_load;
    logic out_buf_en;
    logic soft_rst;
    logic [31:0] other;
  } tpm_src_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic high_side_en;
  } tpm_pin_t;

endpackage

// >>> core/tpm_gpo_select.sv
`timescale 1ns/1ps
module tpm_gpo_select
  import tpm_pkg::*;
(
  // Selection.
  input tpm_sel_t sel,
  input logic test_level,
  // Sources.
  input tpm_src_t src,
  // Result.
  output logic general_purpose_output
);

  function automatic logic [31:0] route(tpm_src_t s, logic t);
    logic [31:0] v;
    v = s.other;
    v[SEL_TEST] = t;
    v[SEL_REF_DIV] = s.ref_div;
    v[SEL_OSC_DIV] = s.osc_div;
    v[SEL_AUX_CLK] = s.aux_clk;
    v[SEL_AUX_EN] = s.aux_en;
    v[SEL_AUX_DOUT] = s.aux_dout;
    v[SEL_PD_DOWN] = s.pd_down;
    v[SEL_PD_UP] = s.pd_up;
    v[SEL_STB_INT] = s.stb_int;
    v[SEL_STB_FRAC] = s.stb_frac;
    v[SEL_STB_AUX] = s.stb_aux;
    v[SEL_LATCH] = s.latch_en;
    v[SEL_DIV_RST] = s.div_sync_rst;
    v[SEL_SEED] = s.seed_load;
    for (int i = SEL_UNUSED_LO; i <= SEL_UNUSED_HI; i++) begin
      v[i] = 1'b0;
    end
    v[SEL_BUF_EN] = s.out_buf_en;
    v[SEL_SOFT_RST] = s.soft_rst;
    return v;
  endfunction

  // The mux is plain logic, so a source change may glitch here; the pin stage samples it.
  logic [31:0] candidates;
  assign candidates = route(src, test_level);
  assign general_purpose_output = candidates[sel];

endmodule

// >>> core/tpm_pin_stage.sv
`timescale 1ns/1ps
module tpm_pin_stage
  import tpm_pkg::*;
(
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Data.
  input logic general_purpose_output,
  input logic serial_read_active,
  input logic serial_read_data,
  // Control.
  input logic disable_read_data_auto_switch,
  input logic pin_driver_force_on,
  input logic high_side_off,
  // Pin.
  output tpm_pin_t pin
);

  logic level_d;
  logic oe_d;
  logic use_read;
  tpm_pin_t pin_q;

  assign use_read = !disable_read_data_auto_switch && serial_read_active;
  assign level_d = use_read ? serial_read_data : general_purpose_output;
  assign oe_d = pin_driver_force_on || serial_read_active;

  // Registering the pin hides mux glitches from the pad at the cost of one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '{level: 1'b0, oe: 1'b0, high_side_en: 1'b1};
    end else begin
      pin_q.level <= level_d;
      pin_q.oe <= oe_d;
      pin_q.high_side_en <= !high_side_off;
    end
  end

  assign pin = pin_q;

endmodule

// >>> dv/tpm_host_model.sv
`timescale 1ns/1ps
module tpm_host_model (
  // Clock.
  input wire logic aclk,
  // Request from the bench.
  input wire logic rd_req,
  input wire logic rd_bit,
  // Serial read port.
  output logic serial_read_active = 1'b0,
  output logic serial_read_data = 1'b0
);
  // Outside a read the data line toggles, so a stale bit never passes for a driven one.
  always @(posedge aclk) begin
    serial_read_active <= rd_req;
    serial_read_data <= rd_req ? rd_bit : ~serial_read_data;
  end
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  import tpm_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [AXI_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [AXI_SW-1:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  tpm_src_t src = '0;
  tpm_pin_t lock_or_read_data_pin;
  logic rd_req = 1'b0, rd_bit = 1'b0, serial_read_active, serial_read_data;
  logic [31:0] m_ctrl, m_sel, rdat;
  logic [63:0] rnd;
  tpm_pin_t ep;
  int fails = 0, compares = 0;

  tpm_test_pin_mux tpm_test_pin_mux_inst (.*);
  tpm_host_model tpm_host_model_inst (.*);

  always #2.5 aclk = ~aclk;

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input tpm_pin_t e);
    compares++;
    if (lock_or_read_data_pin !== e) begin
      fails++;
      $display("unexpected pin expected %b seen %b", e, lock_or_read_data_pin);
    end
  endtask

  // Ready is looked at on the falling edge; it comes from flops, so it equals its value at the next rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar_hit, done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
  endtask

  function automatic logic exp_gpo(input int c, input logic t);
    case (c)
      1: return t;
      9: return src.ref_div;
      10: return src.osc_div;
      13: return src.aux_clk;
      14: return src.aux_en;
      15: return src.aux_dout;
      16: return src.pd_down;
      17: return src.pd_up;
      20: return src.stb_int;
      21: return src.stb_frac;
      22: return src.stb_aux;
      23: return src.latch_en;
      24: return src.div_sync_rst;
      25: return src.seed_load;
      26, 27, 28, 29: return 1'b0;
      30: return src.out_buf_en;
      31: return src.soft_rst;
      default: return src.other[c];
    endcase
  endfunction

  function automatic tpm_pin_t exp_pin(input logic act, input logic b);
    logic g;
    g = exp_gpo(int'(m_sel[4:0]), m_ctrl[5]);
    return '{level: (!m_ctrl[6] && act) ? b : g, oe: m_ctrl[7] || act, high_side_en: !m_ctrl[8]};
  endfunction

  // Host model, register and pin stage each add one edge.
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  initial begin
    void'($urandom(32'h21EE));
    repeat (6) @(posedge aclk);
    chk_pin(3'b001);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(CTRL_OFS);
    chk_reg("ctrl reset", 32'h0, rdat);
    axi_rd(SEL_OFS);
    chk_reg("select reset", 32'h0, rdat);
    $display("test reset done");
    axi_wr(CTRL_OFS, 32'hFFFF_FFFF);
    chk_reg("ctrl bresp", 32'h0, {30'h0, resp});
    axi_rd(CTRL_OFS);
    chk_reg("ctrl bits", 32'h0000_01E0, rdat);
    axi_wr(STAT_OFS, 32'h0);
    chk_reg("status bresp", 32'h2, {30'h0, resp});
    axi_wr(8'h0C, 32'h0);
    chk_reg("unmapped bresp", 32'h2, {30'h0, resp});
    axi_rd(8'h0C);
    chk_reg("unmapped rdata", 32'h0, rdat);
    chk_reg("unmapped rresp", 32'h2, {30'h0, resp});
    $display("test registers done");
    for (int c = 0; c < 64; c++) begin
      @(posedge aclk);
      m_ctrl = c[0] ? 32'h60 : 32'h40;
      m_sel = 32'(c / 2);
      rnd = {$urandom, $urandom};
      src <= rnd[$bits(tpm_src_t)-1:0];
      axi_wr(CTRL_OFS, m_ctrl);
      axi_wr(SEL_OFS, m_sel);
      settle();
      chk_pin(exp_pin(1'b0, 1'b0));
    end
    $display("test select codes done");
    m_sel = 32'h1;
    axi_wr(SEL_OFS, m_sel);
    for (int k = 0; k < 32; k++) begin
      @(posedge aclk);
      m_ctrl = 32'(k % 16) << 5;
      rnd = {$urandom, $urandom};
      rd_req <= k[4];
      rd_bit <= rnd[0];
      axi_wr(CTRL_OFS, m_ctrl);
      settle();
      ep = exp_pin(k[4], rd_bit);
      chk_pin(ep);
      axi_rd(STAT_OFS);
      chk_reg("status", {19'h0, m_sel[4:0], 4'h0, k[4], ep.high_side_en, ep.oe, ep.level}, rdat);
    end
    $display("test pin control done");
    end_sim();
  end

  initial begin
    #50000;
    fails++;
    $display("unexpected watchdog expected done seen hang");
    end_sim();
  end
endmodule
